// ---- logic/pcg_pkg.sv ----
// constants and types shared by the pll and audio clock generator block
package pcg_pkg;
    // clocking of this logic
    localparam int CLK_PERIOD_NS = 40;
    localparam int LOCK_TIME_US = 500;
    localparam int LOCK_CYC = (LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_W = 20;
    localparam int REF_TO_CYC = 16;
    localparam int REF_IDLE_W = 5;
    // pll figures
    localparam int SYS_CLK_KHZ = 270336;
    localparam int REF_NOM_KHZ = 12288;
    localparam int PLL_MULT = SYS_CLK_KHZ / REF_NOM_KHZ;
    localparam int PLL_MULT_W = 5;
    // generator layout
    localparam int NUM_GEN = 3;
    localparam int DOM_PER_GEN = 5;
    localparam int NUM_DOM = NUM_GEN * DOM_PER_GEN;
    localparam int NARROW_W = 9;
    localparam int WIDE_W = 16;
    localparam int ACC_W = WIDE_W + 2;
    localparam int DIV_W = 4;
    localparam int THIRD_GEN = 1;
    localparam logic [1:0] THIRD_SKIP = 2'h2;
    localparam int FRAME_BASE = 512;
    localparam int FRM_W = 10;
    localparam int FRM_TOP = FRM_W - 1;
    localparam int BCLK_SEL_MAX = 4;
    // master clock output
    localparam logic [2:0] MCLK_PRE_DIV = 3'h4;

    typedef enum logic [1:0] {PCG_OFF, PCG_ACQ, PCG_LOCK} pcg_pll_e;

    typedef struct packed {
        logic num_wr;
        logic den_wr;
        logic [1:0] gen;
        logic [WIDE_W-1:0] val;
    } pcg_cfg_s;

    typedef struct packed {
        pcg_pll_e pll;
        logic ref_q;
        logic [REF_IDLE_W-1:0] ref_idle;
        logic [LOCK_W-1:0] lock_cnt;
        logic lock;
        logic core_en;
        logic [2:0] mclk_acc;
        logic mclk;
        logic osc_drive;
        logic [1:0] third;
        logic [NUM_GEN-1:0][WIDE_W-1:0] num;
        logic [NUM_GEN-1:0][WIDE_W-1:0] den;
        logic [NUM_GEN-1:0][ACC_W-1:0] acc;
        logic [NUM_GEN-1:0] tick;
        logic [NUM_GEN-1:0][DIV_W-1:0] div;
        logic [NUM_DOM-1:0][FRM_W-1:0] frm;
        logic [NUM_DOM-1:0] bclk;
        logic [NUM_DOM-1:0] lrclk;
    } pcg_state_s;
endpackage

// ---- logic/pcg_clock_gen.sv ----
// pll lock tracking, master clock output and three n/m audio clock generators
//
// Contract
// - all block clocks come from pll logic
// - core clock nominal and maximum 270.336 MHz
// - pll reference nominally 12.288 MHz
// - lock flag sets once pll is stable
// - lock typically within 500 us
// - three generators give fifteen audio rates
// - frame rate is fin times n over 512m
// - numerator and denominator written independently
// - generators one and two use nine bits
// - generator three uses sixteen bit ratio
// - generator two prescales input by two thirds
// - every domain gives bit and frame clock
// - 32 to 512 bit clocks per sample
// - master clock out is reference over 4 times n
`timescale 1ns/1ns
module pcg_clock_gen #(
    parameter int LOCK_CYC = pcg_pkg::LOCK_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // reference and pll control
    input wire logic i_ref_clk,
    input wire logic i_crystal_drive_in,
    input wire logic i_ref_sel_xtal,
    input wire logic i_pll_en,
    input wire logic [1:0] i_mclk_mul,
    // generator configuration
    input wire pcg_pkg::pcg_cfg_s i_cfg,
    input wire logic [pcg_pkg::NUM_DOM-1:0][2:0] i_bclk_ratio,
    // status and clocks
    output logic o_crystal_drive_out,
    output logic o_pll_lock,
    output logic o_core_clk_en,
    output logic o_mclk_out,
    output logic [pcg_pkg::NUM_DOM-1:0] o_bclk,
    output logic [pcg_pkg::NUM_DOM-1:0] o_lrclk
);
    pcg_pkg::pcg_state_s s_r;
    pcg_pkg::pcg_state_s s_nxt;

    logic ref_now;
    logic ref_edge;
    logic ref_lost;
    logic [2:0] mclk_sum;
    logic [pcg_pkg::ACC_W-1:0] sum;
    logic gen_en;
    logic [pcg_pkg::WIDE_W-1:0] cfg_val;
    logic [pcg_pkg::DIV_W-1:0] dmask;
    logic adv;
    int g;
    int k;
    int bsel;

    always_comb begin
        s_nxt = s_r;
        sum = '0;
        gen_en = 1'b0;
        cfg_val = i_cfg.val;
        dmask = '0;
        adv = 1'b0;
        g = 0;
        k = 0;
        bsel = 0;
        mclk_sum = '0;

        // reference source and activity watch
        ref_now = i_ref_sel_xtal ? i_crystal_drive_in : i_ref_clk;
        ref_edge = ref_now != s_r.ref_q;
        s_nxt.ref_q = ref_now;
        s_nxt.osc_drive = i_ref_sel_xtal & ~i_crystal_drive_in;
        ref_lost = !ref_edge &&
            (s_r.ref_idle == pcg_pkg::REF_IDLE_W'(pcg_pkg::REF_TO_CYC - 1));
        if (ref_edge) begin
            s_nxt.ref_idle = '0;
        end else if (!ref_lost) begin
            s_nxt.ref_idle = s_r.ref_idle + 1'b1;
        end

        // pll lock sequence
        case (s_r.pll)
            pcg_pkg::PCG_OFF: begin
                s_nxt.lock_cnt = '0;
                s_nxt.lock = 1'b0;
                if (i_pll_en) begin
                    s_nxt.pll = pcg_pkg::PCG_ACQ;
                end
            end
            pcg_pkg::PCG_ACQ: begin
                if (!i_pll_en) begin
                    s_nxt.pll = pcg_pkg::PCG_OFF;
                end else if (ref_lost) begin
                    s_nxt.lock_cnt = '0;
                end else if (s_r.lock_cnt == pcg_pkg::LOCK_W'(LOCK_CYC - 1)) begin
                    s_nxt.pll = pcg_pkg::PCG_LOCK;
                    s_nxt.lock = 1'b1;
                end else begin
                    s_nxt.lock_cnt = s_r.lock_cnt + 1'b1;
                end
            end
            pcg_pkg::PCG_LOCK: begin
                if (!i_pll_en || ref_lost) begin
                    s_nxt.pll = i_pll_en ? pcg_pkg::PCG_ACQ : pcg_pkg::PCG_OFF;
                    s_nxt.lock = 1'b0;
                    s_nxt.lock_cnt = '0;
                end
            end
            default: begin
                s_nxt.pll = pcg_pkg::PCG_OFF;
                s_nxt.lock = 1'b0;
            end
        endcase
        // core runs at PLL_MULT times the reference once locked
        s_nxt.core_en = s_nxt.lock;

        // master clock output: reference / 4 * (mul + 1)
        if (!i_pll_en) begin
            s_nxt.mclk_acc = '0;
            s_nxt.mclk = 1'b0;
        end else if (ref_edge) begin
            mclk_sum = s_r.mclk_acc + {1'b0, i_mclk_mul} + 3'h1;
            if (mclk_sum >= pcg_pkg::MCLK_PRE_DIV) begin
                s_nxt.mclk_acc = mclk_sum - pcg_pkg::MCLK_PRE_DIV;
                s_nxt.mclk = ~s_r.mclk;
            end else begin
                s_nxt.mclk_acc = mclk_sum;
            end
        end

        // ratio storage, narrow units keep nine bits
        if (i_cfg.gen < 2'(pcg_pkg::NUM_GEN)) begin
            if (i_cfg.gen != 2'(pcg_pkg::NUM_GEN - 1)) begin
                cfg_val = {{(pcg_pkg::WIDE_W - pcg_pkg::NARROW_W){1'b0}},
                    i_cfg.val[pcg_pkg::NARROW_W-1:0]};
            end
            if (i_cfg.num_wr) begin
                s_nxt.num[i_cfg.gen] = cfg_val;
            end
            if (i_cfg.den_wr) begin
                s_nxt.den[i_cfg.gen] = cfg_val;
            end
        end

        // two-thirds prescale for the second unit
        if (!s_nxt.lock || s_r.third == pcg_pkg::THIRD_SKIP) begin
            s_nxt.third = '0;
        end else begin
            s_nxt.third = s_r.third + 1'b1;
        end

        // n/m accumulators tick at 1024 x frame rate
        for (g = 0; g < pcg_pkg::NUM_GEN; g++) begin
            gen_en = s_r.lock &&
                (g != pcg_pkg::THIRD_GEN || s_r.third != pcg_pkg::THIRD_SKIP);
            sum = s_r.acc[g] + {1'b0, s_r.num[g], 1'b0};
            s_nxt.tick[g] = 1'b0;
            if (!gen_en || s_r.den[g] == '0) begin
                s_nxt.acc[g] = s_r.lock ? s_r.acc[g] : '0;
            end else if (sum >= pcg_pkg::ACC_W'(s_r.den[g])) begin
                s_nxt.tick[g] = 1'b1;
                sum = sum - pcg_pkg::ACC_W'(s_r.den[g]);
                s_nxt.acc[g] = (sum >= pcg_pkg::ACC_W'(s_r.den[g])) ? '0 : sum;
            end else begin
                s_nxt.acc[g] = sum;
            end
            if (!s_r.lock) begin
                s_nxt.div[g] = '0;
            end else if (s_r.tick[g]) begin
                s_nxt.div[g] = s_r.div[g] + 1'b1;
            end
        end

        // five power-of-two fractions per unit, bit and frame from one count
        for (int d = 0; d < pcg_pkg::NUM_DOM; d++) begin
            g = d / pcg_pkg::DOM_PER_GEN;
            k = d % pcg_pkg::DOM_PER_GEN;
            dmask = pcg_pkg::DIV_W'((1 << k) - 1);
            adv = s_r.tick[g] && ((s_r.div[g] & dmask) == dmask);
            bsel = (i_bclk_ratio[d] > 3'(pcg_pkg::BCLK_SEL_MAX)) ?
                0 : pcg_pkg::BCLK_SEL_MAX - int'(i_bclk_ratio[d]);
            if (!s_nxt.lock) begin
                s_nxt.frm[d] = '0;
            end else if (adv) begin
                s_nxt.frm[d] = s_r.frm[d] + 1'b1;
            end
            s_nxt.bclk[d] = s_nxt.lock & s_nxt.frm[d][bsel];
            s_nxt.lrclk[d] = s_nxt.lock & s_nxt.frm[d][pcg_pkg::FRM_TOP];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_crystal_drive_out = s_r.osc_drive;
    assign o_pll_lock = s_r.lock;
    assign o_core_clk_en = s_r.core_en;
    assign o_mclk_out = s_r.mclk;
    assign o_bclk = s_r.bclk;
    assign o_lrclk = s_r.lrclk;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    // last acquire cycle with enable held and reference alive
    sequence seq_acq_done;
        s_r.pll == pcg_pkg::PCG_ACQ && s_r.lock_cnt == pcg_pkg::LOCK_W'(LOCK_CYC - 1) &&
            i_pll_en && !ref_lost;
    endsequence

    a_lock_after_count: assert property ($rose(o_pll_lock) |->
        $past(s_r.pll) == pcg_pkg::PCG_ACQ &&
        $past(s_r.lock_cnt) == pcg_pkg::LOCK_W'(LOCK_CYC - 1))
        else $error("lock rose without full count");
    a_lock_on_count: assert property (seq_acq_done |=> $rose(o_pll_lock))
        else $error("full count did not set lock");
    a_lock_time: assert property (s_r.pll == pcg_pkg::PCG_ACQ |-> s_r.lock_cnt < LOCK_CYC)
        else $error("lock count ran past limit");
    a_ref_loss: assert property (o_pll_lock && ref_lost |=> !o_pll_lock)
        else $error("lock kept after reference loss");
    a_quiet_unlocked: assert property (!o_pll_lock |-> o_bclk == '0 && o_lrclk == '0)
        else $error("audio clock active without lock");
    a_mclk_off: assert property (!i_pll_en |=> !o_mclk_out)
        else $error("master clock out while pll off");
    a_narrow_ratio: assert property (
        s_r.num[0][pcg_pkg::WIDE_W-1:pcg_pkg::NARROW_W] == '0 &&
        s_r.num[1][pcg_pkg::WIDE_W-1:pcg_pkg::NARROW_W] == '0 &&
        s_r.den[0][pcg_pkg::WIDE_W-1:pcg_pkg::NARROW_W] == '0 &&
        s_r.den[1][pcg_pkg::WIDE_W-1:pcg_pkg::NARROW_W] == '0)
        else $error("narrow ratio holds upper bits");
    a_num_store: assert property (i_cfg.num_wr && i_cfg.gen == 2'h2 |=> s_r.num[2] == $past(i_cfg.val))
        else $error("numerator write not stored");
    a_third_skip: assert property (s_r.tick[1] |-> $past(s_r.third) != pcg_pkg::THIRD_SKIP)
        else $error("second unit ticked in skipped slot");
    a_tick_needs_den: assert property (s_r.tick[0] |-> $past(s_r.den[0]) != '0 && $past(o_pll_lock))
        else $error("tick with zero denominator");

    for (genvar d = 0; d < pcg_pkg::NUM_DOM; d++) begin : g_dom_chk
        a_frame_phase: assert property (
            o_pll_lock && $past(o_pll_lock) && $changed(o_lrclk[d])
            |-> $changed(o_bclk[d]))
            else $error("frame edge not on bit edge");
    end
endmodule // pcg_clock_gen

// ---- tb/pcg_ref_src.sv ----
// reference clock and crystal source model for the clock generator bench
`timescale 1ns/1ns
module pcg_ref_src (
    // control
    input wire logic i_clk,
    input wire logic i_run,
    // source clocks
    output logic o_ref,
    output logic o_xtal
);
    int cnt = 0;
    initial begin
        o_ref = 1'b0;
        o_xtal = 1'b0;
    end
    // one level change every two cycles; halts only when told to
    always @(negedge i_clk) begin
        if (i_run) begin
            cnt <= (cnt + 1) % 2;
            if (cnt == 1) begin
                o_ref <= ~o_ref;
                o_xtal <= ~o_xtal;
            end
        end
    end
endmodule // pcg_ref_src

// ---- tb/tb.sv ----
// self-checking bench for the pll lock, master clock and audio clock generators
`timescale 1ns/1ns
module tb;
    localparam int LK = 20;
    logic i_clk, i_sys_rst, ref_clk, xtal, sel, en, run, mon;
    logic [1:0] mul;
    pcg_pkg::pcg_cfg_s cfg;
    logic [pcg_pkg::NUM_DOM-1:0][2:0] br;
    logic xout, lock, core_en, mclk;
    logic [14:0] o_bclk, o_lrclk;
    logic [14:0] pb = '0;
    logic [14:0] pl = '0;
    int bc[15], pc[15], nl[15], bcm[15], pcm[15];
    int fail_count = 0;
    int compares = 0;
    int r;
    logic pm;

    pcg_ref_src pcg_ref_src_inst (.i_clk(i_clk), .i_run(run), .o_ref(ref_clk), .o_xtal(xtal));
    pcg_clock_gen #(.LOCK_CYC(LK)) pcg_clock_gen_inst (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ref_clk(ref_clk), .i_crystal_drive_in(xtal),
        .i_ref_sel_xtal(sel), .i_pll_en(en), .i_mclk_mul(mul), .i_cfg(cfg),
        .i_bclk_ratio(br), .o_crystal_drive_out(xout), .o_pll_lock(lock),
        .o_core_clk_en(core_en), .o_mclk_out(mclk), .o_bclk(o_bclk), .o_lrclk(o_lrclk));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // bit clocks per frame and cycles per frame, per domain
    always @(posedge i_clk) begin
        pb <= o_bclk;
        pl <= o_lrclk;
        for (int d = 0; d < 15; d++) begin
            bc[d] <= bc[d] + int'(o_bclk[d] & ~pb[d]);
            pc[d] <= pc[d] + 1;
            if (!mon) begin
                nl[d] <= 0;
            end else if (o_lrclk[d] & ~pl[d]) begin
                if (nl[d] > 0) begin
                    bcm[d] <= bc[d];
                    pcm[d] <= pc[d];
                end
                nl[d] <= nl[d] + 1;
                bc[d] <= 0;
                // the edge cycle itself opens the new frame
                pc[d] <= 1;
            end
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic n, input logic [1:0] g, input logic [15:0] v);
        @(negedge i_clk);
        cfg.num_wr = n;
        cfg.den_wr = ~n;
        cfg.gen = g;
        cfg.val = v;
        @(negedge i_clk);
        cfg.num_wr = 1'b0;
        cfg.den_wr = 1'b0;
    endtask

    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #(40 * 70000);
        fail_count++;
        summarize();
    end

    initial begin
        i_sys_rst = 1'b1;
        sel = 1'b0;
        en = 1'b0;
        run = 1'b1;
        mon = 1'b0;
        mul = 2'h0;
        cfg = '0;
        for (int d = 0; d < 15; d++) br[d] = 3'(d % 5);
        repeat (12) @(negedge i_clk);
        chk("lrclk in reset", 32'(o_lrclk), 0);
        i_sys_rst = 1'b0;
        // units one and two keep nine bits, unit three all sixteen
        for (int g = 0; g < 2; g++) begin
            wr(1'b1, 2'(g), 16'h0001);
            wr(1'b0, 2'(g), 16'h0202);
        end
        wr(1'b1, 2'h2, 16'h0100);
        wr(1'b0, 2'h2, 16'h0200);
        @(negedge i_clk);
        en = 1'b1;
        repeat (LK) @(negedge i_clk);
        chk("early lock", 32'(lock), 0);
        chk("bclk unlocked", 32'(o_bclk), 0);
        repeat (3) @(negedge i_clk);
        chk("lock", 32'(lock), 1);
        chk("core enable", 32'(core_en), 1);
        for (int m = 0; m < 4; m++) begin
            mul = 2'(m);
            repeat (16) @(negedge i_clk);
            r = 0;
            pm = mclk;
            repeat (512) begin
                @(negedge i_clk);
                r += int'(mclk & ~pm);
                pm = mclk;
            end
            chk("mclk rises", 32'(r >= 32 * (m + 1) - 1 && r <= 32 * (m + 1) + 1), 1);
        end
        mon = 1'b1;
        repeat (50000) @(negedge i_clk);
        for (int d = 0; d < 15; d++) begin
            chk("frame cycles", pcm[d], ((d / 5 == 1) ? 1536 : 1024) << (d % 5));
            chk("bclk per frame", bcm[d], 32 << (d % 5));
        end
        sel = 1'b1;
        @(posedge i_clk);
        #1;
        chk("crystal drive", 32'(xout), 32'(!xtal));
        @(negedge i_clk);
        run = 1'b0;
        repeat (20) @(negedge i_clk);
        chk("lock after loss", 32'(lock), 0);
        chk("frame clocks after loss", 32'(o_lrclk | o_bclk), 0);
        run = 1'b1;
        repeat (LK + 4) @(negedge i_clk);
        chk("relock", 32'(lock), 1);
        en = 1'b0;
        repeat (3) @(negedge i_clk);
        chk("mclk disabled", 32'({lock, mclk}), 0);
        summarize();
    end
endmodule // tb
